// >>> plpl_top.sv
// Look-up table pair: registers, input selection, truth tables and outputs
//
// Function
// R01 - Keeps running regardless of processor debug halt; there is no stop input.
// R02 - Sequencer function writes accepted only while the even table is disabled.
// R03 - Table control settings except enable are locked while that table is enabled.
// R04 - Locked settings accepted in the write that enables, never in one that disables.
// R05 - Global enable bit switches the whole block on or off.
// R06 - Each table has its own enable bit.
// R07 - Output is truth bit indexed by {in2,in1,in0}; masked inputs count as low.
// R08 - Inputs 0 and 1 selected in control B, input 2 in control C.
// R09 - Feedback input takes the pair's sequential element output.
// R10 - Link input takes the next higher table's direct output; table 1 has no higher table here and its link input reads low.
// R11 - Two event lines selectable as inputs; software sets routing first.
// R12 - Filtered output appears two to five table clock ticks later.
// R13 - Filter state cleared one cycle after the table is disabled.
// R14 - Edge detector pulses on each rising edge of its input.
// R15 - Software must pick a valid filter whenever the edge detector is on.
// R16 - Edge detector state cleared one cycle after the table is disabled.
// R17 - Sequential element fed from the path outputs, clocked by the table clock.
// R18 - Disabling the even table clears the sequential element.
// R19 - Gated flip-flop: gate high takes D on the edge, else holds.
// R20 - JK: 00 holds, 01 clears, 10 sets, 11 toggles.
// R21 - Gated latch holds while gate low and follows D while high.
// R22 - RS latch: 00 holds, 01 clears, 10 sets; 11 forbidden.
// R23 - Filter select: 0 none, 1 synchronizer, 2 glitch filter, 3 reserved.
// R24 - Sequencer select: 0 off, 1 flip-flop, 2 JK, 3 latch, 4 RS.
// R25 - Input 2 used as table clock reads as low in the index.
// R26 - Global enable low forces table and sequential outputs low.
`timescale 1ns/1ps
module plpl_top (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       event_line_zero,
	input  wire logic       event_line_one,
	input  wire logic [5:0] pin_in,
	input  wire logic [3:0] periph_in,
	output logic      [1:0] table_out,
	output logic            sequencer_out
);
	plpl_pkg::plpl_top_s st;
	plpl_pkg::plpl_top_s next_st;
	plpl_pair_if         pair ();
	logic [1:0][2:0]     val;
	logic [1:0][2:0]     idx;
	wire  [1:0]          raw;
	wire  [1:0]          tick;
	logic [1:0]          tab_en;
	logic [1:0]          clk_sel;

	function automatic logic [7:0] addr_of(input logic [7:0] base, input int t);
		addr_of = 8'(base + `PLPL_STRIDE * t);
	endfunction

	// R08 R09 R10 R11 per input source mux
	function automatic logic pick(input logic [3:0] sel, input int t, input int y,
		input logic [`PLPL_SYNC_W-1:0] sy, input logic fb, input logic link);
		case (sel)
			`PLPL_SRC_FEEDBACK: pick = fb;
			`PLPL_SRC_LINK:     pick = link;
			`PLPL_SRC_EV0:      pick = sy[`PLPL_SY_EV0];
			`PLPL_SRC_EV1:      pick = sy[`PLPL_SY_EV1];
			`PLPL_SRC_PIN:      pick = sy[`PLPL_SY_PIN0 + 3 * t + y];
			`PLPL_SRC_PER0:     pick = sy[`PLPL_SY_PER0];
			`PLPL_SRC_PER1:     pick = sy[`PLPL_SY_PER0 + 1];
			`PLPL_SRC_PER2:     pick = sy[`PLPL_SY_PER0 + 2];
			`PLPL_SRC_PER3:     pick = sy[`PLPL_SY_PER0 + 3];
			default:            pick = 1'b0;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_table
			assign tab_en[g] = st.glob_en & st.ctl_a[g][`PLPL_A_EN];
			assign clk_sel[g] = st.ctl_a[g][`PLPL_A_CLKSEL];
			// R09 R10 feedback and link wiring
			assign val[g][0] = pick(st.ctl_b[g][`PLPL_B_IN0_HI:`PLPL_B_IN0_LO], g, 0, st.sy2,
				pair.seq_out, (g == 0) ? raw[1] : 1'b0);
			assign val[g][1] = pick(st.ctl_b[g][`PLPL_B_IN1_HI:`PLPL_B_IN1_LO], g, 1, st.sy2,
				pair.seq_out, (g == 0) ? raw[1] : 1'b0);
			assign val[g][2] = pick(st.ctl_c[g], g, 2, st.sy2, pair.seq_out, (g == 0) ? raw[1] : 1'b0);
			// R25 clock input masked in index
			assign idx[g] = {val[g][2] & ~clk_sel[g], val[g][1], val[g][0]};
			// R07 truth table lookup
			assign raw[g] = tab_en[g] & st.truth[g][idx[g]];
			// R01 R17 table clock from peripheral clock or input 2 rising edge
			assign tick[g] = clk_sel[g] ? (val[g][2] & ~st.in2_prev[g]) : 1'b1;
		end
	endgenerate

	assign pair.tick = tick;
	assign pair.en = tab_en;
	assign pair.raw = raw;
	assign pair.filt[0] = st.ctl_a[0][`PLPL_A_FILT_HI:`PLPL_A_FILT_LO];
	assign pair.filt[1] = st.ctl_a[1][`PLPL_A_FILT_HI:`PLPL_A_FILT_LO];
	assign pair.edge_en[0] = st.ctl_a[0][`PLPL_A_EDGE];
	assign pair.edge_en[1] = st.ctl_a[1][`PLPL_A_EDGE];
	assign pair.seq_sel = st.seq_sel;

	plpl_path u_path (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pair    (pair)
	);

	plpl_seq u_seq (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pair    (pair)
	);

	always_comb begin
		next_st = st;
		// Every outside line is asynchronous, so all pass two flops first
		next_st.sy1 = {periph_in, pin_in, event_line_one, event_line_zero};
		next_st.sy2 = st.sy1;
		next_st.in2_prev = {val[1][2], val[0][2]};
		if (reg_wr) begin
			// R05 global enable
			if (reg_addr == `PLPL_ADDR_GLOBAL) begin
				next_st.glob_en = reg_wdata[`PLPL_GLB_EN];
				next_st.glob_stby = reg_wdata[`PLPL_GLB_STBY];
			end
			// R02 sequencer select locked by even table
			if (reg_addr == `PLPL_ADDR_SEQ && !st.ctl_a[0][`PLPL_A_EN]) begin
				next_st.seq_sel = reg_wdata[3:0];
			end
			for (int i = 0; i < 2; i++) begin
				if (reg_addr == addr_of(`PLPL_ADDR_CTLA0, i)) begin
					// R06 table enable always writable
					next_st.ctl_a[i][`PLPL_A_EN] = reg_wdata[`PLPL_A_EN];
					// R03 R04 settings only while currently disabled
					if (!st.ctl_a[i][`PLPL_A_EN]) begin
						next_st.ctl_a[i] = reg_wdata & `PLPL_A_MASK;
					end
				end
				// R03 control B and C locked while enabled
				if (reg_addr == addr_of(`PLPL_ADDR_CTLB0, i) && !st.ctl_a[i][`PLPL_A_EN]) begin
					next_st.ctl_b[i] = reg_wdata;
				end
				if (reg_addr == addr_of(`PLPL_ADDR_CTLC0, i) && !st.ctl_a[i][`PLPL_A_EN]) begin
					next_st.ctl_c[i] = reg_wdata[3:0];
				end
				if (reg_addr == addr_of(`PLPL_ADDR_TRUTH0, i)) begin
					next_st.truth[i] = reg_wdata;
				end
			end
		end
		// Read data live for one cycle only, zero otherwise
		next_st.rdata = `PLPL_RST_BYTE;
		if (reg_rd) begin
			if (reg_addr == `PLPL_ADDR_GLOBAL) begin
				next_st.rdata = {1'b0, st.glob_stby, 5'h00, st.glob_en};
			end
			if (reg_addr == `PLPL_ADDR_SEQ) begin
				next_st.rdata = {4'h0, st.seq_sel};
			end
			if (reg_addr == `PLPL_ADDR_STATUS) begin
				next_st.rdata = {5'h00, st.sout, st.tout};
			end
			for (int i = 0; i < 2; i++) begin
				if (reg_addr == addr_of(`PLPL_ADDR_CTLA0, i)) begin
					next_st.rdata = st.ctl_a[i];
				end
				if (reg_addr == addr_of(`PLPL_ADDR_CTLB0, i)) begin
					next_st.rdata = st.ctl_b[i];
				end
				if (reg_addr == addr_of(`PLPL_ADDR_CTLC0, i)) begin
					next_st.rdata = {4'h0, st.ctl_c[i]};
				end
				if (reg_addr == addr_of(`PLPL_ADDR_TRUTH0, i)) begin
					next_st.rdata = st.truth[i];
				end
			end
		end
		// R26 outputs low while globally off
		next_st.tout = pair.path_out & tab_en;
		next_st.sout = pair.seq_out & st.glob_en;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign table_out = st.tout;
	assign sequencer_out = st.sout;

	a_seq_sel_lock: assert property (@(posedge ref_clk) disable iff (sys_rst) // R02
		reg_wr && reg_addr == `PLPL_ADDR_SEQ && st.ctl_a[0][`PLPL_A_EN]
		|=> st.seq_sel == $past(st.seq_sel)) else $error("Sequencer select changed while locked");
	a_ctla_locked: assert property (@(posedge ref_clk) disable iff (sys_rst) // R03
		reg_wr && reg_addr == `PLPL_ADDR_CTLA0 && st.ctl_a[0][`PLPL_A_EN]
		|=> st.ctl_a[0][7:1] == $past(st.ctl_a[0][7:1])) else $error("Locked control A changed");
	a_ctlb_locked: assert property (@(posedge ref_clk) disable iff (sys_rst) // R03
		reg_wr && reg_addr == `PLPL_ADDR_CTLB0 && st.ctl_a[0][`PLPL_A_EN]
		|=> $stable(st.ctl_b[0])) else $error("Locked control B changed");
	a_enable_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R04
		reg_wr && reg_addr == `PLPL_ADDR_CTLA0 && !st.ctl_a[0][`PLPL_A_EN] && reg_wdata[0]
		|=> st.ctl_a[0] == ($past(reg_wdata) & `PLPL_A_MASK)) else $error("Settings lost on enabling write");
	a_global_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R05
		reg_wr && reg_addr == `PLPL_ADDR_GLOBAL |=> st.glob_en == $past(reg_wdata[0]))
		else $error("Global enable not written");
	a_table_enable: assert property (@(posedge ref_clk) disable iff (sys_rst) // R06
		reg_wr && reg_addr == `PLPL_ADDR_CTLA0 |=> st.ctl_a[0][`PLPL_A_EN] == $past(reg_wdata[`PLPL_A_EN]))
		else $error("Table enable not written");
	a_truth_index: assert property (@(posedge ref_clk) disable iff (sys_rst) // R07
		tab_en[0] && !clk_sel[0] && pair.filt[0] == 2'h0 && !pair.edge_en[0]
		|=> table_out[0] == $past(st.truth[0][{val[0][2], val[0][1], val[0][0]}]))
		else $error("Table output does not match truth bit");
	a_clock_masked: assert property (@(posedge ref_clk) disable iff (sys_rst) // R25
		clk_sel[0] |-> !idx[0][2]) else $error("Clock input not masked in index");
	a_global_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // R26
		!st.glob_en ##1 !st.glob_en |-> table_out == 2'h0 && !sequencer_out)
		else $error("Outputs not low while globally off");
endmodule

// >>> plpl_params.svh
// Register map, field positions and encodings of the look-up table pair
`ifndef PLPL_PARAMS_SVH
`define PLPL_PARAMS_SVH
`define PLPL_ADDR_GLOBAL   8'h00
`define PLPL_ADDR_SEQ      8'h01
`define PLPL_ADDR_CTLA0    8'h05
`define PLPL_ADDR_CTLB0    8'h06
`define PLPL_ADDR_CTLC0    8'h07
`define PLPL_ADDR_TRUTH0   8'h08
`define PLPL_ADDR_STATUS   8'h0D
`define PLPL_STRIDE        4
`define PLPL_RST_BYTE      8'h00
`define PLPL_GLB_EN        0
`define PLPL_GLB_STBY      6
`define PLPL_GLB_MASK      8'h41
`define PLPL_A_EN          0
`define PLPL_A_FILT_LO     4
`define PLPL_A_FILT_HI     5
`define PLPL_A_CLKSEL      6
`define PLPL_A_EDGE        7
`define PLPL_A_MASK        8'hF9
`define PLPL_B_IN0_LO      0
`define PLPL_B_IN0_HI      3
`define PLPL_B_IN1_LO      4
`define PLPL_B_IN1_HI      7
`define PLPL_SRC_MASK      4'h0
`define PLPL_SRC_FEEDBACK  4'h1
`define PLPL_SRC_LINK      4'h2
`define PLPL_SRC_EV0       4'h3
`define PLPL_SRC_EV1       4'h4
`define PLPL_SRC_PIN       4'h5
`define PLPL_SRC_PER0      4'h6
`define PLPL_SRC_PER1      4'h7
`define PLPL_SRC_PER2      4'h8
`define PLPL_SRC_PER3      4'h9
`define PLPL_SYNC_W        12
`define PLPL_SY_EV0        0
`define PLPL_SY_EV1        1
`define PLPL_SY_PIN0       2
`define PLPL_SY_PER0       8
`endif

// >>> plpl_pkg.sv
// Types shared by the look-up table pair modules
package plpl_pkg;
	`include "plpl_params.svh"
	typedef enum logic [3:0] {
		seq_disabled          = 4'h0,
		gated_d_flipflop_mode = 4'h1,
		seq_jk                = 4'h2,
		gated_d_latch_mode    = 4'h3,
		seq_rs                = 4'h4
	} plpl_seq_e;
	typedef enum logic [1:0] {
		filt_none     = 2'h0,
		filt_sync     = 2'h1,
		filt_glitch   = 2'h2,
		filt_reserved = 2'h3
	} plpl_filt_e;
	typedef struct packed {
		logic [2:0] stage;
		logic       held;
		logic       prev;
	} plpl_lane_s;
	typedef struct packed {
		plpl_lane_s [1:0] lane;
	} plpl_path_s;
	typedef struct packed {
		logic q;
	} plpl_seq_s;
	typedef struct packed {
		logic                    glob_en;
		logic                    glob_stby;
		logic [3:0]              seq_sel;
		logic [1:0][7:0]         ctl_a;
		logic [1:0][7:0]         ctl_b;
		logic [1:0][3:0]         ctl_c;
		logic [1:0][7:0]         truth;
		logic [7:0]              rdata;
		logic [`PLPL_SYNC_W-1:0] sy1;
		logic [`PLPL_SYNC_W-1:0] sy2;
		logic [1:0]              in2_prev;
		logic [1:0]              tout;
		logic                    sout;
	} plpl_top_s;
endpackage

// >>> plpl_pair_if.sv
// Signals shared by the control, output path and sequential modules
`timescale 1ns/1ps
interface plpl_pair_if;
	logic [1:0]      tick;
	logic [1:0]      en;
	logic [1:0][1:0] filt;
	logic [1:0]      edge_en;
	logic [1:0]      raw;
	logic [1:0]      path_out;
	logic [3:0]      seq_sel;
	logic            seq_out;
	modport ctrl (output tick, en, filt, edge_en, raw, seq_sel, input path_out, seq_out);
	modport path (input tick, en, filt, edge_en, raw, output path_out);
	modport seq  (input tick, en, path_out, seq_sel, output seq_out);
endinterface

// >>> plpl_path.sv
// Per-table synchronizer, glitch filter and edge detector
`timescale 1ns/1ps
module plpl_path (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	plpl_pair_if.path pair
);
	plpl_pkg::plpl_path_s st;
	plpl_pkg::plpl_path_s next_st;
	logic [1:0]           filt_val;

	always_comb begin
		next_st = st;
		filt_val = 2'h0;
		for (int i = 0; i < 2; i++) begin
			// R23 filter mode decode
			case (plpl_pkg::plpl_filt_e'(pair.filt[i]))
				plpl_pkg::filt_sync:   filt_val[i] = st.lane[i].stage[1];
				plpl_pkg::filt_glitch: filt_val[i] = st.lane[i].held;
				default:               filt_val[i] = pair.raw[i];
			endcase
			// R13 R16 clear after disable
			if (!pair.en[i]) begin
				next_st.lane[i] = '0;
			end else if (pair.tick[i]) begin
				// R12 two to five ticks
				next_st.lane[i].stage = {st.lane[i].stage[1:0], pair.raw[i]};
				if (st.lane[i].stage[1] == st.lane[i].stage[2]) begin
					next_st.lane[i].held = st.lane[i].stage[2];
				end
				next_st.lane[i].prev = filt_val[i];
			end
		end
	end

	// R14 R15 rising edge pulse, meaningless without a filter
	assign pair.path_out[0] = pair.edge_en[0] ? (filt_val[0] & ~st.lane[0].prev) : filt_val[0];
	assign pair.path_out[1] = pair.edge_en[1] ? (filt_val[1] & ~st.lane[1].prev) : filt_val[1];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_filter_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
		!pair.en[0] |=> st.lane[0] == '0) else $error("Filter state not cleared after disable");
	a_sync_delay: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
		(pair.en[0] && pair.tick[0] && pair.filt[0] == 2'h1 && !pair.edge_en[0])[*3]
		|-> pair.path_out[0] == $past(pair.raw[0], 2)) else $error("Synchronizer delay wrong");
endmodule

// >>> plpl_seq.sv
// Shared sequential element of the table pair
`timescale 1ns/1ps
module plpl_seq (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	plpl_pair_if.seq  pair
);
	plpl_pkg::plpl_seq_s st;
	plpl_pkg::plpl_seq_s next_st;
	logic                d_in;
	logic                g_in;

	assign d_in = pair.path_out[0];
	assign g_in = pair.path_out[1];

	always_comb begin
		next_st = st;
		// R18 cleared while even table off
		if (!pair.en[0]) begin
			next_st.q = 1'b0;
		end else begin
			// R24 function decode
			case (plpl_pkg::plpl_seq_e'(pair.seq_sel))
				// R19 gated flip-flop
				plpl_pkg::gated_d_flipflop_mode: if (pair.tick[0] && g_in) next_st.q = d_in;
				// R20 jk flip-flop
				plpl_pkg::seq_jk: if (pair.tick[0]) begin
					case ({d_in, g_in})
						2'h1:    next_st.q = 1'b0;
						2'h2:    next_st.q = 1'b1;
						2'h3:    next_st.q = ~st.q;
						default: next_st.q = st.q;
					endcase
				end
				// R21 latch follows while gate high
				plpl_pkg::gated_d_latch_mode: if (g_in) next_st.q = d_in;
				// R22 set reset latch, both high holds
				plpl_pkg::seq_rs: begin
					if (d_in && !g_in) next_st.q = 1'b1;
					if (g_in && !d_in) next_st.q = 1'b0;
				end
				default: next_st.q = 1'b0;
			endcase
		end
	end

	assign pair.seq_out = st.q;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_even_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
		!pair.en[0] |=> !pair.seq_out) else $error("Sequential output not cleared");
	a_jk_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst) // R20
		pair.en[0] && pair.seq_sel == 4'h2 && pair.tick[0] && d_in && g_in
		|=> pair.seq_out == !$past(pair.seq_out)) else $error("JK toggle failed");
	a_dff_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
		pair.en[0] && pair.seq_sel == 4'h1 && !g_in |=> $stable(pair.seq_out)) else $error("Gated flip-flop did not hold");
endmodule

// >>> plpl_far_model.sv
// Far-side model: event lines, pin inputs and peripheral outputs feeding the table pair
`timescale 1ns/1ps
module plpl_far_model (
	input  wire logic       ref_clk,
	input  wire logic [1:0] ev_req,
	input  wire logic [5:0] pin_req,
	input  wire logic [3:0] per_req,
	output logic            event_line_zero,
	output logic            event_line_one,
	output logic      [5:0] pin_in,
	output logic      [3:0] periph_in
);
	logic [11:0] lines = 12'h000;
	assign {periph_in, pin_in, event_line_one, event_line_zero} = lines;
	// event lines stay low until the bench routes them
	always @(posedge ref_clk) begin
		lines <= {per_req, pin_req, ev_req};
	end
endmodule

// >>> plpl_top_test.sv
// Self-checking testbench of the look-up table pair
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module plpl_top_test;
	logic       ref_clk;
	logic       sys_rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       ev0;
	logic       ev1;
	logic [5:0] pin_in;
	logic [3:0] periph_in;
	logic [1:0] table_out;
	logic       sequencer_out;
	logic [1:0] ev_req;
	logic [5:0] pin_req;
	logic [3:0] per_req;
	int         failures;
	int         n_tests;

	plpl_far_model far (.ref_clk(ref_clk), .ev_req(ev_req), .pin_req(pin_req), .per_req(per_req),
		.event_line_zero(ev0), .event_line_one(ev1), .pin_in(pin_in), .periph_in(periph_in));
	plpl_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_line_zero(ev0),
		.event_line_one(ev1), .pin_in(pin_in), .periph_in(periph_in), .table_out(table_out),
		.sequencer_out(sequencer_out));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// Disable first so the protected fields are always taken
	task cfg(input logic t, input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] tt);
		logic [7:0] ba;
		ba = t ? 8'h09 : 8'h05;
		wr(ba, 8'h00);
		wr(ba + 8'h01, b);
		wr(ba + 8'h02, c);
		wr(ba + 8'h03, tt);
		wr(ba, a);
	endtask

	task t_regs;
		for (int a = 0; a < 14; a++) rd(8'(a), 8'h00);
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h00);
		wr(8'h06, 8'h55);
		wr(8'h05, 8'h01);
		wr(8'h06, 8'h33);
		rd(8'h06, 8'h55);
		wr(8'h05, 8'h31);
		rd(8'h05, 8'h01);
		wr(8'h05, 8'h30);
		rd(8'h05, 8'h00);
		wr(8'h05, 8'h31);
		rd(8'h05, 8'h31);
		wr(8'h01, 8'h02);
		rd(8'h01, 8'h00);
		wr(8'h05, 8'h00);
		wr(8'h01, 8'h04);
		rd(8'h01, 8'h04);
		wr(8'h01, 8'h00);
		wr(8'h06, 8'h00);
	endtask

	task t_truth;
		wr(8'h00, 8'h01);
		cfg(1'b0, 8'h01, 8'h55, 8'h05, 8'h96);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk) pin_req <= 6'(i);
			cyc(6);
			`CHK(table_out[0], 8'h96 >> i & 1'b1)
		end
		wr(8'h00, 8'h00);
		cyc(3);
		`CHK(table_out, 2'b00)
		wr(8'h00, 8'h01);
		cyc(4);
		`CHK(table_out[0], 1'b1)
		wr(8'h05, 8'h00);
		cyc(3);
		`CHK(table_out[0], 1'b0)
	endtask

	task t_src;
		for (int s = 3; s < 10; s++) begin
			cfg(1'b0, 8'h01, 8'(s), 8'h00, 8'hAA);
			@(posedge ref_clk);
			ev_req  <= {s == 4, s == 3};
			pin_req <= {5'b0, s == 5};
			per_req <= (s > 5) ? 4'(1 << (s - 6)) : 4'h0;
			cyc(6);
			`CHK(table_out[0], 1'b1)
			@(posedge ref_clk) {ev_req, pin_req, per_req} <= '0;
			cyc(6);
			`CHK(table_out[0], 1'b0)
		end
		cfg(1'b1, 8'h01, 8'h05, 8'h00, 8'hAA);
		cfg(1'b0, 8'h01, 8'h02, 8'h00, 8'hAA);
		@(posedge ref_clk) pin_req <= 6'h08;
		cyc(8);
		`CHK(table_out[0], 1'b1)
		`CHK(table_out[1], 1'b1)
		@(posedge ref_clk) pin_req <= 6'h00;
	endtask

	task t_filter;
		int n[4];
		for (int f = 0; f < 4; f++) begin
			cfg(1'b0, {2'b00, 2'(f), 4'h1}, 8'h05, 8'h00, 8'hAA);
			@(posedge ref_clk) pin_req <= 6'h00;
			cyc(10);
			@(posedge ref_clk) pin_req <= 6'h01;
			n[f] = 0;
			while (table_out[0] !== 1'b1 && n[f] < 20) begin
				cyc(1);
				n[f]++;
			end
		end
		`CHK(n[1] - n[0] inside {[2:5]}, 1'b1)
		`CHK(n[2] - n[0] inside {[2:5]}, 1'b1)
		`CHK(n[3], n[0])
	endtask

	// Edge detection always runs behind the synchronizer, as a valid filter is required
	task t_edge;
		int c;
		for (int k = 0; k < 4; k++) begin
			if (k == 0 || k == 2) begin
				// Pin settles while the table is off, so enabling it makes no edge
				@(posedge ref_clk) pin_req <= {5'b0, k == 2};
				cfg(1'b0, 8'h91, 8'h05, 8'h00, (k == 0) ? 8'hAA : 8'h55);
			end
			@(posedge ref_clk) pin_req <= {5'b0, k == 0 || k == 2};
			c = 0;
			for (int i = 0; i < 15; i++) begin
				cyc(1);
				c += (table_out[0] === 1'b1);
			end
			`CHK(c, (k == 0 || k == 3) ? 1 : 0)
		end
	endtask

	task t_clk;
		cfg(1'b0, 8'h41, 8'h00, 8'h05, 8'h0F);
		repeat (4) begin
			@(posedge ref_clk) pin_req <= 6'h04;
			cyc(4);
			@(posedge ref_clk) pin_req <= 6'h00;
			cyc(4);
		end
		@(posedge ref_clk) pin_req <= 6'h04;
		cyc(6);
		`CHK(table_out[0], 1'b1)
		@(posedge ref_clk) pin_req <= 6'h00;
	endtask

	// Gate or reset line is written before data so no unwanted step is seen
	task st(input logic t0, input logic t1, input logic e);
		wr(8'h0C, {8{t1}});
		wr(8'h08, {8{t0}});
		cyc(8);
		`CHK(sequencer_out, e)
	endtask

	task t_seq;
		cfg(1'b1, 8'h01, 8'h00, 8'h00, 8'h00);
		for (int m = 1; m < 5; m++) begin
			wr(8'h05, 8'h00);
			cyc(3);
			`CHK(sequencer_out, 1'b0)
			wr(8'h01, 8'(m));
			cfg(1'b0, 8'h01, 8'h00, 8'h00, 8'h00);
			// Ends set, so the clear on the next disable is visible
			st(1'b0, 1'b1, 1'b0);
			st(1'b1, m == 1 || m == 3, 1'b1);
			st(1'b0, 1'b0, 1'b1);
			if (m == 2) begin
				// Both high toggles on every edge, starting from the clear
				wr(8'h0C, 8'hFF);
				wr(8'h08, 8'hFF);
				cyc(2);
				`CHK(sequencer_out, 1'b1)
				cyc(1);
				`CHK(sequencer_out, 1'b0)
			end
		end
		wr(8'h05, 8'h00);
	endtask

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#800000;
		failures++;
		stop_test();
	end

	initial begin
		failures  = 0;
		n_tests   = 0;
		sys_rst   = 1'b1;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		ev_req    = 2'b00;
		pin_req   = 6'h00;
		per_req   = 4'h0;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_truth();
		t_src();
		t_filter();
		t_edge();
		t_clk();
		t_seq();
		stop_test();
	end
endmodule
